/* cfd_core.v */
// control-flow decode and execute unit with an apb register port
// assumes a zero-wait apb master on sys_clk and an asynchronous irq_req pin
`include "cfd_defs.vh"

module cfd_core
#(
   parameter STK_AW = 4
)
(
   // clock and reset
   input  wire        sys_clk,
   input  wire        rstn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // interrupt request pin and acceptance pulse
   input  wire        irq_req,
   output reg         irq_ack
);

   localparam ST_IDLE = 3'b001;
   localparam ST_EXEC = 3'b010;
   localparam ST_IRQ  = 3'b100;

   // decode: {len[1:0], cycles[4:0], class[4:0]}
   function [11:0] dec;
      input [7:0] op;
      begin
         dec = {2'd1, 5'd1, `CFD_CL_UND};
         if (op == 8'h00)
            dec = {2'd1, 5'd1, `CFD_CL_NOP};
         else if (op == 8'he0)
            dec = {2'd1, 5'd2, `CFD_CL_JMPA};
         else if (op == 8'h21)
            dec = {2'd3, 5'd3, `CFD_CL_JMPX};
         else if (op[7:3] == 5'b11101)
            dec = {2'd1, 5'd6, `CFD_CL_VECTOR_CALL_OP};
         else if (op == 8'h31)
            dec = {2'd3, 5'd6, `CFD_CL_CALL};
         else if (op == 8'hf4)
            dec = {2'd1, 5'd3, `CFD_CL_WORD_EXCHANGE_OP};
         else if (op == 8'h20)
            dec = {2'd1, 5'd4, `CFD_CL_RET};
         else if (op == 8'h30)
            dec = {2'd1, 5'd6, `CFD_CL_INTERRUPT_RETURN_OP};
         else if (op == 8'h40)
            dec = {2'd1, 5'd4, `CFD_CL_PUSHA};
         else if (op == 8'h50)
            dec = {2'd1, 5'd4, `CFD_CL_POPA};
         else if (op == 8'h41)
            dec = {2'd1, 5'd4, `CFD_CL_PUSHX};
         else if (op == 8'h51)
            dec = {2'd1, 5'd4, `CFD_CL_POPX};
         else if (op == 8'h81)
            dec = {2'd1, 5'd1, `CFD_CL_CARRY_CLEAR_OP};
         else if (op == 8'h91)
            dec = {2'd1, 5'd1, `CFD_CL_CARRY_SET_OP};
         else if (op == 8'h80)
            dec = {2'd1, 5'd1, `CFD_CL_IRQ_FLAG_CLEAR_OP};
         else if (op == 8'h90)
            dec = {2'd1, 5'd1, `CFD_CL_IRQ_FLAG_SET_OP};
         // direct bit clear, set and test
         else if (op[7:3] == 5'b10100)
            dec = {2'd2, 5'd4, `CFD_CL_BIT_CLEAR_OP};
         else if (op[7:3] == 5'b10101)
            dec = {2'd2, 5'd4, `CFD_CL_BIT_SET_OP};
         else if (op[7:3] == 5'b10110)
            dec = {2'd3, 5'd5, `CFD_CL_BBC};
         else if (op[7:3] == 5'b10111)
            dec = {2'd3, 5'd5, `CFD_CL_BBS};
         else if (op[7:3] == 5'b11111)
            dec = {2'd2, 5'd3, `CFD_CL_BCC};
      end
   endfunction

   // branch condition from the low three opcode bits
   function cond;
      input [2:0] sel;
      input [4:0] ps;
      begin
         case (sel)
            3'd0: cond = ~ps[`CFD_F_C];
            3'd1: cond = ps[`CFD_F_C];
            3'd2: cond = ~ps[`CFD_F_N];
            3'd3: cond = ps[`CFD_F_N];
            3'd4: cond = ~ps[`CFD_F_Z];
            3'd5: cond = ps[`CFD_F_Z];
            3'd6: cond = ~(ps[`CFD_F_N] ^ ps[`CFD_F_V]);
            default: cond = ps[`CFD_F_N] ^ ps[`CFD_F_V];
         endcase
      end
   endfunction

   reg [2:0]  st_r;
   reg [4:0]  cnt_r;
   reg [4:0]  cls_r;
   reg [1:0]  len_r;
   reg [7:0]  op_r;
   reg [15:0] opnd_r;
   reg        und_r;
   reg [15:0] pc_r;
   reg [15:0] acc_r;
   reg [15:0] ix_r;
   reg [15:0] sp_r;
   reg [4:0]  ps_r;
   reg [15:0] irqv_r;
   reg [2:0]  irq_sync_r;
   reg        irq_lvl_r;
   reg [15:0] stk   [0:(1<<STK_AW)-1];
   reg [7:0]  dpmem [0:7];
   reg [15:0] vec   [0:7];

   wire        busy    = ~st_r[0];
   wire        setup   = psel & ~penable;
   wire        access  = psel & penable;
   wire        commit  = busy & (cnt_r == 5'd1);
   wire [11:0] dec_w   = dec(pwdata[7:0]);
   wire [STK_AW-1:0] sp_i  = sp_r[STK_AW-1:0];
   wire [STK_AW-1:0] sp_m1 = sp_i - {{(STK_AW-1){1'b0}}, 1'b1};
   wire [STK_AW-1:0] sp_m2 = sp_i - {{(STK_AW-2){1'b0}}, 2'b10};
   wire [STK_AW-1:0] sp_p1 = sp_i + {{(STK_AW-1){1'b0}}, 1'b1};
   wire [15:0] pc_next = pc_r + {14'h0000, len_r};
   wire [15:0] rel8    = {{8{opnd_r[7]}}, opnd_r[7:0]};
   wire [15:0] rel16   = {{8{opnd_r[15]}}, opnd_r[15:8]};
   wire [7:0]  dp_byte = dpmem[opnd_r[2:0]];
   wire        dp_bit  = dp_byte[op_r[2:0]];
   wire        in_dp   = (paddr[7:5] == 3'b001);
   wire        in_vec  = (paddr[7:5] == 3'b010);
   wire        in_core = (paddr[7:5] == 3'b000) & (paddr[1:0] == 2'b00);
   wire        mapped  = (in_dp | in_vec | in_core) & (paddr[1:0] == 2'b00);
   // every register is write-locked while busy, and status is never writable
   wire        wr_ok   = mapped & ~busy & (paddr != `CFD_OFF_STAT);
   wire        wr_en   = access & pwrite & wr_ok;
   wire        ins_wr  = wr_en & (paddr == `CFD_OFF_INSN);

   // zero-wait slave; bad address or locked write flags an error
   assign pready  = 1'b1;
   assign pslverr = access & (~mapped | (pwrite & ~wr_ok));

   // pin synchroniser: stage 1 feeds stage 2 only, level moves when 2 and 3 agree
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irq_sync_r <= 3'b000;
         irq_lvl_r  <= 1'b0;
      end
      else
      begin
         irq_sync_r <= {irq_sync_r[1:0], irq_req};
         if (irq_sync_r[1] == irq_sync_r[2])
            irq_lvl_r <= irq_sync_r[2];
      end
   end

   // read data is latched in the setup phase so it is a flop in the access phase
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         prdata <= 32'h0000_0000;
      else if (setup)
      begin
         prdata <= 32'h0000_0000;
         if (in_dp)
            prdata <= {24'h000000, dpmem[paddr[4:2]]};
         else if (in_vec)
            prdata <= {16'h0000, vec[paddr[4:2]]};
         else
            case (paddr)
               `CFD_OFF_INSN: prdata <= {8'h00, opnd_r, op_r};
               `CFD_OFF_STAT: prdata <= {16'h0000, und_r, len_r, cnt_r, cls_r, busy,
                                         irq_lvl_r, 1'b0};
               `CFD_OFF_PC:   prdata <= {16'h0000, pc_r};
               `CFD_OFF_ACC:  prdata <= {16'h0000, acc_r};
               `CFD_OFF_IX:   prdata <= {16'h0000, ix_r};
               `CFD_OFF_SP:   prdata <= {16'h0000, sp_r};
               `CFD_OFF_PS:   prdata <= {27'h0000000, ps_r};
               `CFD_OFF_IRQV: prdata <= {16'h0000, irqv_r};
               default:       prdata <= 32'h0000_0000;
            endcase
      end
   end

   // memories: stack, direct page and vector table; no reset, software loads them
   always @(posedge sys_clk)
   begin
      if (wr_en & in_dp)
         dpmem[paddr[4:2]] <= pwdata[7:0];
      if (wr_en & in_vec)
         vec[paddr[4:2]] <= pwdata[15:0];
      if (commit & st_r[2])
      begin
         // interrupt entry stacks pc first, then flags on top
         stk[sp_m1] <= pc_r;
         stk[sp_m2] <= {11'h000, ps_r};
      end
      else if (commit)
         case (cls_r)
            `CFD_CL_VECTOR_CALL_OP, `CFD_CL_CALL: stk[sp_m1] <= pc_next;
            `CFD_CL_PUSHA: stk[sp_m1] <= acc_r;
            `CFD_CL_PUSHX: stk[sp_m1] <= ix_r;
            `CFD_CL_BIT_CLEAR_OP:  dpmem[opnd_r[2:0]] <= dp_byte & ~(8'h01 << op_r[2:0]);
            `CFD_CL_BIT_SET_OP:  dpmem[opnd_r[2:0]] <= dp_byte | (8'h01 << op_r[2:0]);
            default: ;
         endcase
   end

   // sequencer and architectural registers
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_r    <= ST_IDLE;
         cnt_r   <= 5'd0;
         cls_r   <= `CFD_CL_NOP;
         len_r   <= 2'd0;
         op_r    <= 8'h00;
         opnd_r  <= 16'h0000;
         und_r   <= 1'b0;
         pc_r    <= `CFD_RST_PC;
         acc_r   <= 16'h0000;
         ix_r    <= 16'h0000;
         sp_r    <= `CFD_RST_SP;
         ps_r    <= `CFD_RST_PS;
         irqv_r  <= 16'h0000;
         irq_ack <= 1'b0;
      end
      else
      begin
         irq_ack <= 1'b0;
         // plain register writes, only accepted while idle
         if (wr_en)
            case (paddr)
               `CFD_OFF_PC:   pc_r   <= pwdata[15:0];
               `CFD_OFF_ACC:  acc_r  <= pwdata[15:0];
               `CFD_OFF_IX:   ix_r   <= pwdata[15:0];
               `CFD_OFF_SP:   sp_r   <= pwdata[15:0];
               `CFD_OFF_PS:   ps_r   <= pwdata[4:0];
               `CFD_OFF_IRQV: irqv_r <= pwdata[15:0];
               default: ;
            endcase
         case (st_r)
            ST_IDLE:
            begin
               // software issue beats a pending interrupt in the same cycle
               if (ins_wr)
               begin
                  op_r   <= pwdata[7:0];
                  opnd_r <= pwdata[23:8];
                  len_r  <= dec_w[11:10];
                  cnt_r  <= dec_w[9:5];
                  cls_r  <= dec_w[4:0];
                  und_r  <= (dec_w[4:0] == `CFD_CL_UND);
                  st_r   <= ST_EXEC;
               end
               else if (irq_lvl_r & ps_r[`CFD_F_I])
               begin
                  cnt_r   <= `CFD_IRQ_CYC;
                  irq_ack <= 1'b1;
                  st_r    <= ST_IRQ;
               end
            end
            ST_IRQ:
            begin
               cnt_r <= cnt_r - 5'd1;
               if (commit)
               begin
                  sp_r              <= sp_r - 16'h0002;
                  pc_r              <= irqv_r;
                  ps_r[`CFD_F_I]    <= 1'b0;
                  st_r              <= ST_IDLE;
               end
            end
            ST_EXEC:
            begin
               cnt_r <= cnt_r - 5'd1;
               if (commit)
               begin
                  st_r <= ST_IDLE;
                  pc_r <= pc_next;
                  case (cls_r)
                     `CFD_CL_JMPA: pc_r <= acc_r;
                     `CFD_CL_JMPX: pc_r <= opnd_r;
                     // vector selected by low opcode bits
                     `CFD_CL_VECTOR_CALL_OP:
                     begin
                        pc_r <= vec[op_r[2:0]];
                        sp_r <= sp_r - 16'h0001;
                     end
                     `CFD_CL_CALL:
                     begin
                        pc_r <= opnd_r;
                        sp_r <= sp_r - 16'h0001;
                     end
                     `CFD_CL_WORD_EXCHANGE_OP:
                     begin
                        pc_r  <= acc_r;
                        acc_r <= pc_r + 16'h0001;
                     end
                     `CFD_CL_RET:
                     begin
                        pc_r <= stk[sp_i];
                        sp_r <= sp_r + 16'h0001;
                     end
                     // flags then pc off the stack
                     `CFD_CL_INTERRUPT_RETURN_OP:
                     begin
                        ps_r <= stk[sp_i][4:0];
                        pc_r <= stk[sp_p1];
                        sp_r <= sp_r + 16'h0002;
                     end
                     `CFD_CL_PUSHA: sp_r <= sp_r - 16'h0001;
                     `CFD_CL_POPA:
                     begin
                        acc_r <= stk[sp_i];
                        sp_r  <= sp_r + 16'h0001;
                     end
                     `CFD_CL_PUSHX: sp_r <= sp_r - 16'h0001;
                     `CFD_CL_POPX:
                     begin
                        ix_r <= stk[sp_i];
                        sp_r <= sp_r + 16'h0001;
                     end
                     `CFD_CL_CARRY_CLEAR_OP: ps_r[`CFD_F_C] <= 1'b0;
                     `CFD_CL_CARRY_SET_OP: ps_r[`CFD_F_C] <= 1'b1;
                     `CFD_CL_IRQ_FLAG_CLEAR_OP: ps_r[`CFD_F_I] <= 1'b0;
                     `CFD_CL_IRQ_FLAG_SET_OP: ps_r[`CFD_F_I] <= 1'b1;
                     // bit test branches, z shows the inverted bit
                     `CFD_CL_BBC:
                     begin
                        ps_r[`CFD_F_Z] <= ~dp_bit;
                        if (!dp_bit)
                           pc_r <= pc_next + rel16;
                     end
                     `CFD_CL_BBS:
                     begin
                        ps_r[`CFD_F_Z] <= ~dp_bit;
                        if (dp_bit)
                           pc_r <= pc_next + rel16;
                     end
                     `CFD_CL_BCC:
                        if (cond(op_r[2:0], ps_r))
                           pc_r <= pc_next + rel8;
                     default: ;
                  endcase
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

endmodule

/* cfd_core_properties.sv */
// checker for cfd_core: busy windows, apb refusals, interrupt gating
// assumes it is bound to cfd_core and sees only that module's ports
module cfd_props (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rstn,
   // apb and interrupt pins
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq_req,
   input wire logic        irq_ack
);
   logic [3:0] cnt_r;
   logic       ien_r;
   logic       acc;
   logic       wr_ok;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // access phase and an accepted write
   assign acc   = psel && penable;
   assign wr_ok = acc && pwrite && !pslverr;
   // busy length each opcode should give
   function automatic logic [3:0] cyc(input logic [7:0] op);
      casez (op)
         8'he0: cyc = 4'h2;
         8'h21, 8'hf4, 8'b1111_1???: cyc = 4'h3;
         8'h20, 8'h40, 8'h41, 8'h50, 8'h51, 8'b1010_????: cyc = 4'h4;
         8'b1011_????: cyc = 4'h5;
         8'h30, 8'h31, 8'b1110_1???: cyc = 4'h6;
         default: cyc = 4'h1;
      endcase
   endfunction
   // shadows of busy cycles left and of the interrupt flag; the flag is taken
   // as set after a return from interrupt, which can only weaken the gating
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_r <= 4'h0;
         ien_r <= 1'b0;
      end
      else
      begin
         if (wr_ok && paddr == 8'h00)
            cnt_r <= cyc(pwdata[7:0]);
         else if (irq_ack)
            cnt_r <= 4'h5;
         else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
         if (wr_ok && paddr == 8'h18)
            ien_r <= pwdata[4];
         else if (wr_ok && paddr == 8'h00 && pwdata[7:0] == 8'h80)
            ien_r <= 1'b0;
         else if (wr_ok && paddr == 8'h00 && (pwdata[7:0] == 8'h90 || pwdata[7:0] == 8'h30))
            ien_r <= 1'b1;
         else if (irq_ack)
            ien_r <= 1'b0;
      end
   end
   sequence s_ack;
      irq_ack;
   endsequence
   sequence s_quiet;
      !irq_ack [*5];
   endsequence
   a_busy_refuse: assert property (acc && pwrite && paddr == 8'h00 && cnt_r != 4'h0 |-> pslverr)
      else $error("instruction taken while busy");
   a_idle_accept: assert property (acc && pwrite && paddr == 8'h00 && cnt_r == 4'h0 && !irq_ack |-> !pslverr)
      else $error("instruction refused while idle");
   a_reg_busy: assert property (acc && pwrite && paddr inside {8'h08, 8'h0c, 8'h10, 8'h14, 8'h18} && cnt_r != 4'h0 |-> pslverr)
      else $error("register write taken while busy");
   a_ack_gated: assert property (s_ack |-> $past(ien_r))
      else $error("interrupt taken with flag clear");
   a_ack_idle: assert property (s_ack |-> cnt_r == 4'h0 && $past(cnt_r) == 4'h0)
      else $error("interrupt taken while busy");
   a_ack_pulse: assert property (s_ack |=> s_quiet)
      else $error("interrupt pulse too long or repeated");
   a_bad_addr: assert property (acc && (paddr[1:0] != 2'b00 || paddr >= 8'h60) |-> pslverr)
      else $error("bad address not refused");
   a_bad_rdata: assert property (acc && !pwrite && paddr >= 8'h60 |-> prdata == 32'h0)
      else $error("bad address read not zero");
endmodule

bind cfd_core cfd_props u_props (
   .sys_clk(sys_clk),
   .rstn(rstn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .irq_req(irq_req),
   .irq_ack(irq_ack)
);

/* cfd_core_tb.sv */
// self-checking bench for cfd_core: opcode table, branches, stack, interrupt
// assumes the zero-wait apb port of cfd_core and the offsets in cfd_defs.vh
`include "cfd_defs.vh"
module cfd_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [23:0] insn;
      logic [15:0] acc;
      logic [4:0]  ps;
      logic [15:0] pc_x;
      logic [15:0] acc_x;
      logic [4:0]  ps_x;
      logic [3:0]  n;
   } cfd_row_t;
   logic        sys_clk;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq_req;
   logic        irq_ack;
   logic [31:0] rd;
   logic        err;
   int          error_cnt;
   int          compares;
   int          k;
   // insn, acc, ps in; pc, acc, ps out; busy cycles
   cfd_row_t rows [12] = '{
      '{24'h0000e0, 16'h4321, 5'h00, 16'h4321, 16'h4321, 5'h00, 4'h2},
      '{24'hbeef21, 16'h0000, 5'h00, 16'hbeef, 16'h0000, 5'h00, 4'h3},
      '{24'h0000e8, 16'h0000, 5'h00, 16'h2000, 16'h0000, 5'h00, 4'h6},
      '{24'h0000ef, 16'h0000, 5'h00, 16'h2070, 16'h0000, 5'h00, 4'h6},
      '{24'h345631, 16'h0000, 5'h00, 16'h3456, 16'h0000, 5'h00, 4'h6},
      '{24'h0000f4, 16'h5555, 5'h00, 16'h5555, 16'h0101, 5'h00, 4'h3},
      '{24'h000081, 16'h0000, 5'h0f, 16'h0101, 16'h0000, 5'h0e, 4'h1},
      '{24'h000091, 16'h0000, 5'h00, 16'h0101, 16'h0000, 5'h01, 4'h1},
      '{24'h000080, 16'h0000, 5'h1f, 16'h0101, 16'h0000, 5'h0f, 4'h1},
      '{24'h000090, 16'h0000, 5'h0f, 16'h0101, 16'h0000, 5'h1f, 4'h1},
      '{24'h000000, 16'h0000, 5'h00, 16'h0101, 16'h0000, 5'h00, 4'h1},
      '{24'h000001, 16'h0000, 5'h00, 16'h0101, 16'h0000, 5'h00, 4'h1}
   };
   cfd_core uut (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .irq_req(irq_req),
      .irq_ack(irq_ack)
   );
   // 40 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic finish_test;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; leaves the bus asserted so another may follow at once
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
   endtask
   task automatic idle;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
      idle;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0);
      idle;
      cmp(rd, x);
   endtask
   task automatic prep(input logic [15:0] pc, input logic [15:0] a, input logic [4:0] p);
      wr(`CFD_OFF_PC, {16'h0, pc});
      wr(`CFD_OFF_ACC, {16'h0, a});
      wr(`CFD_OFF_PS, {27'h0, p});
      wr(`CFD_OFF_SP, 32'h10);
   endtask
   // issue an instruction, then write a spare byte on the first idle cycle
   task automatic run(input logic [23:0] insn, input int n);
      xfer(1'b1, `CFD_OFF_INSN, {8'h00, insn});
      cmp({31'h0, err}, 32'h0);
      if (n > 1)
      begin
         idle;
         repeat (n - 2) @(posedge sys_clk);
      end
      xfer(1'b1, 8'h3c, 32'h0);
      cmp({31'h0, err}, 32'h0);
      idle;
   endtask
   function automatic logic br_taken(input logic [2:0] i, input logic [4:0] p);
      logic f;
      case (i[2:1])
         2'd0: f = p[0];
         2'd1: f = p[3];
         2'd2: f = p[2];
         default: f = p[3] ^ p[1];
      endcase
      return i[0] ? f : !f;
   endfunction
   // watchdog well beyond the thousand or so cycles the run needs
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      finish_test;
   end
   initial
   begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      irq_req = 1'b0;
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      rchk(`CFD_OFF_PC, 32'h0);
      rchk(`CFD_OFF_PS, 32'h0);
      xfer(1'b0, 8'h60, 32'h0);
      idle;
      cmp({31'h0, err}, 32'h1);
      cmp(rd, 32'h0);
      wr(8'h40, 32'h2000);
      wr(8'h5c, 32'h2070);
      foreach (rows[i])
      begin
         prep(16'h0100, rows[i].acc, rows[i].ps);
         run(rows[i].insn, rows[i].n);
         rchk(`CFD_OFF_PC, {16'h0, rows[i].pc_x});
         rchk(`CFD_OFF_ACC, {16'h0, rows[i].acc_x});
         rchk(`CFD_OFF_PS, {27'h0, rows[i].ps_x});
      end
      // the last row was an unused opcode: status shows it, length one, idle
      rchk(`CFD_OFF_STAT, 32'h0000a0a8);
      // every branch condition with its flag both clear and set
      for (k = 0; k < 16; k++)
      begin
         prep(16'h0100, 16'h0, k[0] ? 5'h0d : 5'h00);
         run({8'h00, 8'h10, 5'h1f, k[3:1]}, 3);
         rchk(`CFD_OFF_PC, br_taken(k[3:1], k[0] ? 5'h0d : 5'h00) ? 32'h112 : 32'h102);
      end
      // writes during a call are refused; return pops the pushed address
      prep(16'h0100, 16'h0, 5'h00);
      xfer(1'b1, `CFD_OFF_INSN, 32'h00345631);
      xfer(1'b1, `CFD_OFF_PC, 32'h0);
      cmp({31'h0, err}, 32'h1);
      xfer(1'b1, `CFD_OFF_INSN, 32'h0);
      cmp({31'h0, err}, 32'h1);
      idle;
      repeat (4) @(posedge sys_clk);
      rchk(`CFD_OFF_SP, 32'h0f);
      run(24'h000020, 4);
      rchk(`CFD_OFF_PC, 32'h0103);
      rchk(`CFD_OFF_SP, 32'h10);
      // word push and pop of accumulator and index pointer
      prep(16'h0100, 16'ha5c3, 5'h0f);
      run(24'h000040, 4);
      wr(`CFD_OFF_ACC, 32'h0);
      run(24'h000050, 4);
      rchk(`CFD_OFF_ACC, 32'ha5c3);
      wr(`CFD_OFF_IX, 32'h1234);
      run(24'h000041, 4);
      wr(`CFD_OFF_IX, 32'h0);
      run(24'h000051, 4);
      rchk(`CFD_OFF_IX, 32'h1234);
      rchk(`CFD_OFF_PS, 32'h0f);
      // direct bit set, clear, then branch on the cleared bit
      wr(8'h28, 32'h0);
      run(24'h0002ab, 4);
      rchk(8'h28, 32'h08);
      run(24'h0002a3, 4);
      rchk(8'h28, 32'h00);
      prep(16'h0100, 16'h0, 5'h00);
      run(24'h2002b3, 5);
      rchk(`CFD_OFF_PC, 32'h0123);
      // interrupt masked while the flag is clear, taken once it is set
      prep(16'h0100, 16'h0, 5'h00);
      wr(`CFD_OFF_IRQV, 32'h0800);
      irq_req <= 1'b1;
      repeat (20) @(posedge sys_clk);
      rchk(`CFD_OFF_PC, 32'h0100);
      wr(`CFD_OFF_PS, 32'h1a);
      k = 0;
      while (irq_ack !== 1'b1 && k < 20)
      begin
         @(posedge sys_clk);
         k++;
      end
      irq_req <= 1'b0;
      cmp({31'h0, irq_ack}, 32'h1);
      repeat (8) @(posedge sys_clk);
      rchk(`CFD_OFF_PC, 32'h0800);
      wr(`CFD_OFF_PS, 32'h0);
      run(24'h000030, 6);
      rchk(`CFD_OFF_PC, 32'h0100);
      rchk(`CFD_OFF_PS, 32'h1a);
      // reset in mid-run returns the flags and stack pointer to zero
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      rchk(`CFD_OFF_PS, 32'h0);
      rchk(`CFD_OFF_SP, 32'h0);
      finish_test;
   end
endmodule

/* cfd_defs.vh */
// constants for the control-flow decode and execute unit
// assumes an apb master on sys_clk and byte addresses on paddr
`ifndef CFD_DEFS_VH
`define CFD_DEFS_VH
// register byte offsets
`define CFD_OFF_INSN   8'h00
`define CFD_OFF_STAT   8'h04
`define CFD_OFF_PC     8'h08
`define CFD_OFF_ACC    8'h0c
`define CFD_OFF_IX     8'h10
`define CFD_OFF_SP     8'h14
`define CFD_OFF_PS     8'h18
`define CFD_OFF_IRQV   8'h1c
`define CFD_OFF_DP     8'h20
`define CFD_OFF_VEC    8'h40
// reset values
`define CFD_RST_PC     16'h0000
`define CFD_RST_SP     16'h0000
`define CFD_RST_PS     5'h00
// flag positions in ps
`define CFD_F_C        0
`define CFD_F_V        1
`define CFD_F_Z        2
`define CFD_F_N        3
`define CFD_F_I        4
// decode classes
`define CFD_CL_NOP     5'h00
`define CFD_CL_JMPA    5'h01
`define CFD_CL_JMPX    5'h02
`define CFD_CL_VECTOR_CALL_OP   5'h03
`define CFD_CL_CALL    5'h04
`define CFD_CL_WORD_EXCHANGE_OP    5'h05
`define CFD_CL_RET     5'h06
`define CFD_CL_INTERRUPT_RETURN_OP    5'h07
`define CFD_CL_PUSHA   5'h08
`define CFD_CL_POPA    5'h09
`define CFD_CL_PUSHX   5'h0a
`define CFD_CL_POPX    5'h0b
`define CFD_CL_CARRY_CLEAR_OP    5'h0c
`define CFD_CL_CARRY_SET_OP    5'h0d
`define CFD_CL_IRQ_FLAG_CLEAR_OP    5'h0e
`define CFD_CL_IRQ_FLAG_SET_OP    5'h0f
`define CFD_CL_BIT_CLEAR_OP    5'h10
`define CFD_CL_BIT_SET_OP    5'h11
`define CFD_CL_BBC     5'h12
`define CFD_CL_BBS     5'h13
`define CFD_CL_BCC     5'h14
`define CFD_CL_UND     5'h15
// interrupt entry length in cycles
`define CFD_IRQ_CYC    5'h06
`endif
